/* include/sdrbrw_pkg.sv */
// Package: shared constants, command enum and command-bus carrier for the SDRAM core
package sdrbrw_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int         BANKS         = 4;
    localparam int         BANK_W        = 2;
    localparam int         ADDR_W        = 13;
    localparam int         AP_BIT        = 10;
    localparam int         MAX_CL        = 3;
    // ------------------------------------------------------------------
    // Timing and modes
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         DQM_OUT_LAT   = 2;
    localparam logic [2:0] BL_FULL       = 3'h7;
    localparam logic [1:0] CL_RESET      = 2'h2;

    typedef enum {
        CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ,
        CMD_WRITE, CMD_PRECHARGE, CMD_BST, CMD_OTHER
    } sdrbrw_cmd_t;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } sdrbrw_cmd_bus_t;
endpackage : sdrbrw_pkg

/* rtl/sdrbrw_core.sv */
// SDRAM core: bank activation, read and write bursts, DQ mask and truncation
`timescale 1ns/1ps
`default_nettype none
module sdrbrw_core
    import sdrbrw_pkg::*;
#(
    parameter int DQ_W  = 16,
    parameter int DQM_W = 2,
    parameter int COL_W = 9
) (
    // Clock, reset, enable
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // Command and data pins
    input  wire sdrbrw_cmd_bus_t              cmd_bus,
    input  wire logic [DQM_W-1:0]             dqm,
    input  wire logic [DQ_W-1:0]              dq_in,
    output logic      [DQ_W-1:0]              dq_out,
    output logic      [DQ_W-1:0]              dq_oe,
    // Configuration
    input  wire logic [1:0]                   read_latency,
    input  wire logic [2:0]                   burst_len_code,
    // Status
    output logic      [BANKS-1:0]             bank_open,
    output logic      [BANKS-1:0][ADDR_W-1:0] bank_row,
    output logic                              read_busy,
    output logic                              write_busy,
    output logic                              write_invalid
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int WORDS  = BANKS << COL_W;
    localparam int IDX_W  = BANK_W + COL_W;
    localparam int LANE_W = DQ_W / DQM_W;

    sdrbrw_cmd_t         cmd;
    logic [BANK_W-1:0]   c_bank;
    logic [COL_W-1:0]    c_col;
    logic                c_ap;
    logic                bl_full;
    logic [COL_W-1:0]    bl_mask;
    logic [DQ_W-1:0]     mem_r [WORDS];
    logic [DQ_W-1:0]     wr_keep;
    logic [DQ_W-1:0]     wr_word;
    logic [DQM_W-1:0]    dqm_d1_r;
    logic [DQM_W-1:0]    dqm_d2_r;
    logic [MAX_CL-1:0]   pipe_vld_r;
    logic [DQ_W-1:0]     pipe_dat_r [MAX_CL];
    logic [1:0]          out_sel;
    logic [MAX_CL-1:0]   vld_live;
    logic                rd_out_vld;
    logic                rd_act_r, rd_ap_r, rd_fetch, rd_f_last, rd_f_ap, rd_close;
    logic [BANK_W-1:0]   rd_bank_r, rd_f_bank;
    logic [COL_W-1:0]    rd_col_r, rd_f_col, rd_cnt_r;
    logic                wr_act_r, wr_ap_r, wr_ok_r, wr_go, wr_f_last, wr_f_ap, wr_close;
    logic                wr_f_ok, wr_bad, rd_pending;
    logic [BANK_W-1:0]   wr_bank_r, wr_f_bank;
    logic [COL_W-1:0]    wr_col_r, wr_f_col, wr_cnt_r;

    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] col,
                                                  input logic [COL_W-1:0] mask);
        // Fixed bursts wrap inside their block, full page wraps at page end
        return (col & ~mask) | ((col + 1'b1) & mask);
    endfunction : next_col

    function automatic logic pre_hit(input sdrbrw_cmd_t c, input logic ap,
                                     input logic [BANK_W-1:0] cb,
                                     input logic [BANK_W-1:0] b);
        return (c == CMD_PRECHARGE) && (ap || cb == b);
    endfunction : pre_hit

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    assign c_bank  = cmd_bus.bank;
    assign c_col   = cmd_bus.addr[COL_W-1:0];
    assign c_ap    = cmd_bus.addr[AP_BIT];
    assign bl_full = (burst_len_code == BL_FULL);
    assign bl_mask = bl_full ? '1 : COL_W'((32'd1 << burst_len_code[1:0]) - 32'd1);

    always_comb begin
        case ({cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n})
            3'h7:    cmd = CMD_NOP;
            3'h3:    cmd = CMD_ACTIVE;
            3'h5:    cmd = CMD_READ;
            3'h4:    cmd = CMD_WRITE;
            3'h2:    cmd = CMD_PRECHARGE;
            3'h6:    cmd = CMD_BST;
            default: cmd = CMD_OTHER;
        endcase
        if (cmd_bus.cs_n) begin
            cmd = CMD_INHIBIT;
        end
    end

    // ------------------------------------------------------------------
    // Read burst sequencing
    // ------------------------------------------------------------------
    // A new READ replaces the running burst on the same edge, so data flows on
    always_comb begin
        rd_fetch  = (cmd == CMD_READ) ||
                    (rd_act_r && cmd != CMD_BST && cmd != CMD_WRITE &&
                     !pre_hit(cmd, c_ap, c_bank, rd_bank_r));
        rd_f_bank = (cmd == CMD_READ) ? c_bank : rd_bank_r;
        rd_f_col  = (cmd == CMD_READ) ? c_col : rd_col_r;
        rd_f_ap   = (cmd == CMD_READ) ? c_ap : rd_ap_r;
        rd_f_last = !bl_full && ((cmd == CMD_READ) ? (bl_mask == '0) : (rd_cnt_r == bl_mask));
        rd_close  = rd_fetch && rd_f_last && rd_f_ap;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_act_r  <= 1'b0;
            rd_ap_r   <= 1'b0;
            rd_bank_r <= '0;
            rd_col_r  <= '0;
            rd_cnt_r  <= '0;
        end else if (ce) begin
            rd_act_r <= rd_fetch && !rd_f_last;
            if (rd_fetch) begin
                rd_bank_r <= rd_f_bank;
                rd_ap_r   <= rd_f_ap;
                rd_col_r  <= next_col(rd_f_col, bl_mask);
                rd_cnt_r  <= (cmd == CMD_READ) ? COL_W'(1) : rd_cnt_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data pipeline and output mask
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pipe_vld_r <= '0;
            dqm_d1_r   <= '0;
            dqm_d2_r   <= '0;
        end else if (ce) begin
            dqm_d1_r <= dqm;
            dqm_d2_r <= dqm_d1_r;
            // A registered WRITE kills all read data still in flight
            if (cmd == CMD_WRITE) begin
                pipe_vld_r <= '0;
            end else begin
                pipe_vld_r <= {pipe_vld_r[MAX_CL-2:0], rd_fetch};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            pipe_dat_r[0] <= mem_r[{rd_f_bank, rd_f_col}];
            for (int k = 1; k < MAX_CL; k++) begin
                pipe_dat_r[k] <= pipe_dat_r[k-1];
            end
        end
    end

    assign out_sel    = (read_latency == 2'h0) ? 2'h0 : read_latency - 2'h1;
    assign rd_out_vld = pipe_vld_r[out_sel];
    assign dq_out     = pipe_dat_r[out_sel];

    // Per-lane mask: two-clock latency on outputs, zero on inputs
    for (genvar l = 0; l < DQM_W; l++) begin : g_lane
        assign dq_oe[l*LANE_W +: LANE_W]   = {LANE_W{rd_out_vld && !dqm_d2_r[l]}};
        assign wr_keep[l*LANE_W +: LANE_W] = {LANE_W{dqm[l]}};
    end

    // ------------------------------------------------------------------
    // Write burst sequencing and array
    // ------------------------------------------------------------------
    // Stages past the selected latency keep stale bits; they are not in flight
    assign vld_live   = pipe_vld_r & ~({MAX_CL{1'b1}} << (out_sel + 2'h1));
    assign rd_pending = (|vld_live) || rd_act_r;
    // Read output not masked the clock before: the truncating write is void
    assign wr_bad     = rd_pending && !(&dqm_d1_r);

    always_comb begin
        wr_go     = (cmd == CMD_WRITE) ||
                    (wr_act_r && cmd != CMD_READ && cmd != CMD_BST &&
                     !pre_hit(cmd, c_ap, c_bank, wr_bank_r));
        wr_f_bank = (cmd == CMD_WRITE) ? c_bank : wr_bank_r;
        wr_f_col  = (cmd == CMD_WRITE) ? c_col : wr_col_r;
        wr_f_ap   = (cmd == CMD_WRITE) ? c_ap : wr_ap_r;
        wr_f_ok   = (cmd == CMD_WRITE) ? !wr_bad : wr_ok_r;
        wr_f_last = !bl_full && ((cmd == CMD_WRITE) ? (bl_mask == '0) : (wr_cnt_r == bl_mask));
        wr_close  = wr_go && wr_f_last && wr_f_ap;
        wr_word   = (mem_r[{wr_f_bank, wr_f_col}] & wr_keep) | (dq_in & ~wr_keep);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_act_r      <= 1'b0;
            wr_ap_r       <= 1'b0;
            wr_ok_r       <= 1'b0;
            wr_bank_r     <= '0;
            wr_col_r      <= '0;
            wr_cnt_r      <= '0;
            write_invalid <= 1'b0;
        end else if (ce) begin
            // Finished fixed bursts drop out, later data is ignored
            wr_act_r      <= wr_go && !wr_f_last;
            write_invalid <= (cmd == CMD_WRITE) && wr_bad;
            if (wr_go) begin
                wr_bank_r <= wr_f_bank;
                wr_ap_r   <= wr_f_ap;
                wr_ok_r   <= wr_f_ok;
                wr_col_r  <= next_col(wr_f_col, bl_mask);
                wr_cnt_r  <= (cmd == CMD_WRITE) ? COL_W'(1) : wr_cnt_r + 1'b1;
            end
        end
    end

    // No row bits in the array: contents are shared by all rows of a bank
    always_ff @(posedge clk) begin
        if (ce && wr_go && wr_f_ok) begin
            mem_r[{wr_f_bank, wr_f_col}] <= wr_word;
        end
    end

    // ------------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------------
    // Any bank may be activated while another is bursting
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_ff @(posedge clk) begin
            if (rst) begin
                bank_open[b] <= 1'b0;
                bank_row[b]  <= '0;
            end else if (ce) begin
                if (cmd == CMD_ACTIVE && c_bank == BANK_W'(b)) begin
                    bank_open[b] <= 1'b1;
                    bank_row[b]  <= cmd_bus.addr;
                end else if (pre_hit(cmd, c_ap, c_bank, BANK_W'(b)) ||
                             (rd_close && rd_f_bank == BANK_W'(b)) ||
                             (wr_close && wr_f_bank == BANK_W'(b))) begin
                    bank_open[b] <= 1'b0;
                end
            end
        end
    end

    assign read_busy  = rd_pending;
    assign write_busy = wr_act_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    read_first_a: assert property (@(posedge clk) disable iff (rst)
        (ce && cmd == CMD_READ && read_latency == 2'h2) ##1 (ce && cmd == CMD_NOP)
        |=> rd_out_vld && dq_out == $past(mem_r[{c_bank, c_col}], 2))
        else $error("read data not presented at read latency");
    write_hiz_a: assert property (@(posedge clk) disable iff (rst)
        ce && cmd == CMD_WRITE |=> dq_oe == '0 ##1 (dq_oe == '0 || $past(cmd) == CMD_READ))
        else $error("pins driven after truncating write");
    read_mask_a: assert property (@(posedge clk) disable iff (rst)
        (ce && (&dqm)) ##1 ce |=> dq_oe == '0)
        else $error("masked read data driven");
    auto_pre_a: assert property (@(posedge clk) disable iff (rst)
        ce && rd_close && !(cmd == CMD_ACTIVE) |=> !bank_open[$past(rd_f_bank)])
        else $error("auto precharge did not close bank");
    act_open_a: assert property (@(posedge clk) disable iff (rst)
        ce && cmd == CMD_ACTIVE |=> bank_open[$past(c_bank)]
        && bank_row[$past(c_bank)] == $past(cmd_bus.addr))
        else $error("active did not open row");
    pre_all_a: assert property (@(posedge clk) disable iff (rst)
        ce && cmd == CMD_PRECHARGE && c_ap |=> bank_open == '0)
        else $error("precharge all left a bank open");
    page_wrap_a: assert property (@(posedge clk) disable iff (rst)
        ce && rd_fetch && bl_full && rd_f_col == '1
        |=> rd_act_r && rd_col_r == '0)
        else $error("full page burst did not wrap");
    write_data_a: assert property (@(posedge clk) disable iff (rst)
        ce && cmd == CMD_WRITE && dqm == '0 && !wr_bad
        |=> mem_r[$past({c_bank, c_col})] == $past(dq_in))
        else $error("write data not stored on command edge");
    freeze_a: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(bank_open) && $stable(pipe_vld_r) && $stable(wr_act_r))
        else $error("state moved while clock enable low");
    write_end_a: assert property (@(posedge clk) disable iff (rst)
        ce && wr_go && wr_f_last ##1 (ce && cmd == CMD_NOP) |-> !wr_go)
        else $error("write burst ran past its length");
endmodule : sdrbrw_core
`default_nettype wire

/* testbench/sdrbrw_core_tb.sv */
// Testbench for the SDRAM core: bursts, masking, truncation, bank state
`timescale 1ns/1ps
`default_nettype none
module sdrbrw_core_tb
    import sdrbrw_pkg::*;
;
    localparam logic [15:0] ON = 16'hffff;
    logic                         clk = 1'b0;
    logic                         rst;
    logic                         ce;
    sdrbrw_cmd_bus_t              cmd_bus;
    logic [1:0]                   dqm;
    logic [15:0]                  dq_in;
    logic [15:0]                  dq_out;
    logic [15:0]                  dq_oe;
    logic [1:0]                   read_latency;
    logic [2:0]                   burst_len_code;
    logic [3:0]                   bank_open;
    logic [3:0][12:0]             bank_row;
    logic                         read_busy;
    logic                         write_busy;
    logic                         write_invalid;
    int                           checks = 0;
    int                           miscompares = 0;

    always #10 clk = ~clk;

    sdrbrw_core sdrbrw_core_i (.clk(clk), .rst(rst), .ce(ce), .cmd_bus(cmd_bus), .dqm(dqm),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .read_latency(read_latency),
        .burst_len_code(burst_len_code), .bank_open(bank_open), .bank_row(bank_row),
        .read_busy(read_busy), .write_busy(write_busy), .write_invalid(write_invalid));
    sdrbrw_ctrl_model sdrbrw_ctrl_model_i (.clk(clk), .cmd_bus(cmd_bus), .dqm(dqm),
        .dq_in(dq_in));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic obs(input logic [15:0] oe, input logic [15:0] d);
        check("dq_oe", dq_oe, oe);
        if (oe != 16'h0) check("dq_out", dq_out, d);
    endtask : obs

    task automatic drv(input sdrbrw_cmd_t k, input logic [12:0] a, input logic [1:0] m,
                       input logic [15:0] d);
        sdrbrw_ctrl_model_i.put(k, 2'h1, a, m, d);
    endtask : drv

    task automatic go(input sdrbrw_cmd_t k, input logic [12:0] a, input logic [1:0] m);
        sdrbrw_ctrl_model_i.cmd(k, 2'h1, a, m);
    endtask : go

    task automatic nop(input int n);
        sdrbrw_ctrl_model_i.idle(n, 2'h0);
    endtask : nop

    task automatic t_chain();
        sdrbrw_ctrl_model_i.open_row(2'h1, 13'h0123);
        check("bank_open", bank_open, 4'h2);
        check("bank_row", bank_row[1], 13'h0123);
        drv(CMD_WRITE, 13'h0006, 2'h0, 16'hc0c6);
        drv(CMD_NOP, 13'h0, 2'h0, 16'hd0d7);
        check("write_busy", write_busy, 1'b1);
        drv(CMD_WRITE, 13'h0004, 2'h0, 16'ha0a4);
        drv(CMD_NOP, 13'h0, 2'h0, 16'hb0b5);
        drv(CMD_NOP, 13'h0, 2'h0, 16'he0e0);
        nop(1);
        go(CMD_READ, 13'h0004, 2'h0);
        nop(1);
        obs(16'h0, 16'h0);
        check("read_busy", read_busy, 1'b1);
        go(CMD_READ, 13'h0006, 2'h0);
        obs(ON, 16'ha0a4);
        nop(1);
        obs(ON, 16'hb0b5);
        nop(1);
        obs(ON, 16'hc0c6);
        nop(1);
        obs(ON, 16'hd0d7);
        nop(1);
        obs(16'h0, 16'h0);
        check("read_busy", read_busy, 1'b0);
        $display("test chain done");
    endtask : t_chain

    // Read cut by a write; mask high two ahead silences the pins
    // A voided write carries other data, so the readback proves nothing was stored
    task automatic t_mask(input logic [1:0] late_mask, input logic [15:0] first);
        logic [15:0] exp [4] = '{16'h5550, 16'h6661, 16'h3372, 16'h8883};
        logic [15:0] key = (late_mask == 2'h3) ? 16'h0000 : 16'h0f0f;
        go(CMD_READ, 13'h0008, 2'h0);
        go(CMD_NOP, 13'h0, 2'h0);
        go(CMD_NOP, 13'h0, 2'h3);
        go(CMD_NOP, 13'h0, late_mask);
        obs(ON, first);
        drv(CMD_WRITE, 13'h0008, 2'h0, 16'h5550 ^ key);
        obs(16'h0, 16'h0);
        drv(CMD_NOP, 13'h0, 2'h0, 16'h6661 ^ key);
        obs(16'h0, 16'h0);
        check("write_invalid", write_invalid, late_mask != 2'h3);
        drv(CMD_NOP, 13'h0, 2'h2, 16'h7772 ^ key);
        drv(CMD_NOP, 13'h0, 2'h0, 16'h8883 ^ key);
        nop(1);
        go(CMD_READ, 13'h0008, 2'h0);
        nop(2);
        foreach (exp[i]) begin
            nop(1);
            obs(ON, exp[i]);
        end
        $display("test mask done");
    endtask : t_mask

    task automatic t_page(input sdrbrw_cmd_t stop);
        sdrbrw_ctrl_model_i.put(CMD_WRITE, 2'h2, 13'h01ff, 2'h0, 16'h0f0f);
        sdrbrw_ctrl_model_i.put(CMD_NOP, 2'h2, 13'h0, 2'h0, 16'hf0f0);
        sdrbrw_ctrl_model_i.put(CMD_BST, 2'h2, 13'h0, 2'h0, 16'h1234);
        nop(1);
        sdrbrw_ctrl_model_i.cmd(CMD_READ, 2'h2, 13'h01ff, 2'h0);
        nop(1);
        sdrbrw_ctrl_model_i.cmd(stop, 2'h2, 13'h0, 2'h0);
        obs(ON, 16'h0f0f);
        nop(1);
        obs(ON, 16'hf0f0);
        nop(1);
        obs(16'h0, 16'h0);
        nop(2);
        check("bank_open", bank_open[2], stop != CMD_PRECHARGE);
        $display("test page done");
    endtask : t_page

    task automatic t_auto();
        go(CMD_READ, 13'h0408, 2'h0);
        nop(7);
        check("bank_open", bank_open, 4'h0);
        $display("test auto done");
    endtask : t_auto

    // Clock enable low mid-burst: shown word and burst position hold
    task automatic t_freeze();
        sdrbrw_ctrl_model_i.cmd(CMD_READ, 2'h2, 13'h01ff, 2'h0);
        nop(1);
        nop(1);
        obs(ON, 16'h0f0f);
        ce = 1'b0;
        nop(1);
        obs(ON, 16'h0f0f);
        check("read_busy", read_busy, 1'b1);
        sdrbrw_ctrl_model_i.cmd(CMD_BST, 2'h2, 13'h0, 2'h0);
        obs(ON, 16'h0f0f);
        ce = 1'b1;
        nop(1);
        obs(ON, 16'hf0f0);
        nop(1);
        obs(16'h0, 16'h0);
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_close();
        sdrbrw_ctrl_model_i.open_row(2'h3, 13'h0077);
        check("bank_open", bank_open, 4'hc);
        sdrbrw_ctrl_model_i.close_row(2'h3);
        check("bank_open", bank_open, 4'h4);
        sdrbrw_ctrl_model_i.cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0);
        nop(1);
        check("bank_open", bank_open, 4'h0);
        $display("test close done");
    endtask : t_close

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        read_latency = 2'h2;
        burst_len_code = 3'h1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check("bank_open", bank_open, 4'h0);
        check("idle", {dq_oe, read_busy, write_busy, write_invalid}, 19'h0);
        t_chain();
        read_latency = 2'h3;
        burst_len_code = 3'h2;
        drv(CMD_WRITE, 13'h0008, 2'h0, 16'h1110);
        drv(CMD_NOP, 13'h0, 2'h0, 16'h2221);
        drv(CMD_NOP, 13'h0, 2'h0, 16'h3332);
        drv(CMD_NOP, 13'h0, 2'h0, 16'h4443);
        t_mask(2'h3, 16'h1110);
        t_mask(2'h0, 16'h5550);
        read_latency = 2'h2;
        t_auto();
        burst_len_code = 3'h7;
        sdrbrw_ctrl_model_i.open_row(2'h2, 13'h0055);
        t_page(CMD_BST);
        t_page(CMD_PRECHARGE);
        sdrbrw_ctrl_model_i.open_row(2'h2, 13'h0055);
        t_freeze();
        t_close();
        stop_test();
    end

    // Whole run is about 110 cycles
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : sdrbrw_core_tb
`default_nettype wire

/* testbench/sdrbrw_ctrl_model.sv */
// Memory controller model: commands, masks and write data toward the core
`timescale 1ns/1ps
`default_nettype none
module sdrbrw_ctrl_model
    import sdrbrw_pkg::*;
#(
    parameter int ACT_ACCESS_CYC = 2,
    parameter int PRECHARGE_CYC  = 2
) (
    // Clock
    input  wire logic            clk,
    // Pins toward the device
    output var sdrbrw_cmd_bus_t  cmd_bus,
    output var logic [1:0]       dqm,
    output var logic [15:0]      dq_in
);
    initial begin
        cmd_bus = '1;
        dqm     = 2'h0;
        dq_in   = 16'h0000;
    end

    // Pins move at the falling edge only, so the rising edge sees them settled
    task automatic put(input sdrbrw_cmd_t k, input logic [1:0] b, input logic [12:0] a,
                       input logic [1:0] m, input logic [15:0] d);
        logic [2:0] rcw;
        case (k)
            CMD_ACTIVE:    rcw = 3'h3;
            CMD_READ:      rcw = 3'h5;
            CMD_WRITE:     rcw = 3'h4;
            CMD_PRECHARGE: rcw = 3'h2;
            CMD_BST:       rcw = 3'h6;
            default:       rcw = 3'h7;
        endcase
        @(negedge clk);
        cmd_bus = {1'b0, rcw, b, a};
        dqm     = m;
        dq_in   = d;
    endtask : put

    // Released data lines toggle, so a stale value never reads as good data
    task automatic cmd(input sdrbrw_cmd_t k, input logic [1:0] b, input logic [12:0] a,
                       input logic [1:0] m);
        put(k, b, a, m, ~dq_in);
    endtask : cmd

    task automatic idle(input int n, input logic [1:0] m);
        repeat (n) cmd(CMD_NOP, 2'h0, 13'h0000, m);
    endtask : idle

    // Row opened first, access held back by the activate delay
    task automatic open_row(input logic [1:0] b, input logic [12:0] row);
        cmd(CMD_ACTIVE, b, row, 2'h0);
        idle(ACT_ACCESS_CYC, 2'h0);
    endtask : open_row

    // Bank left alone for the whole precharge period
    task automatic close_row(input logic [1:0] b);
        cmd(CMD_PRECHARGE, b, 13'h0000, 2'h0);
        idle(PRECHARGE_CYC, 2'h0);
    endtask : close_row
endmodule : sdrbrw_ctrl_model
`default_nettype wire
